// ---- lbhp_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Narrow mode: lane2 low byte, lane1 high.
// - Narrow mode: lane0 enable tied low.
// - Upper data lanes only in wide modes.
// - Lower data lanes used in every mode.
// - Low strobe marks start of cycle.
// - Wide modes: size16 low for narrow resources.
// - Narrow mode: size16 never driven.
// - Double modes: bus clock from ready-return.
// - Single mode: ready-return wired to ready.
// - Single mode: time from single-rate clock.
// - Single clock may be halved double clock.
// - Double modes: single clock grounded.
// - Processor reset high aligns bus phase.
// - Single mode: processor reset still wired.
// - Three-state interrupt, control register governed.
// - Claim low before middle of T2.
// - Qualifier high memory, low I/O.
// - Write qualifier high write, low read.
// - Watch ready in double modes only; drive only ending own cycles.
module lbhp_device (
  lbhp_if.dev                       bus,
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire lbhp_pkg::lbhp_mode_e bus_mode,
  input  wire logic                 dev_ack,
  input  wire logic [31:0]          dev_rdata,
  input  wire logic                 irq_event,
  input  wire logic [1:0]           interrupt_control_reg,
  output logic                      dev_req,
  output logic [23:2]               dev_addr,
  output logic                      dev_mem,
  output logic                      dev_write,
  output logic [3:0]                dev_be,
  output logic [31:0]               dev_wdata,
  output logic                      irq_pending
);
  typedef enum logic [1:0] {
    D_IDLE   = 2'b00,
    D_CLAIM  = 2'b01,
    D_ACCESS = 2'b11,
    D_READY  = 2'b10
  } lbhp_dstate_e;

  lbhp_dstate_e state_r;
  lbhp_dstate_e state_nxt;
  logic         dbl_mode;
  logic         wide_mode;
  logic         clk_src;
  logic         src_prev_r;
  logic         src_rise;
  logic         phase_r;
  logic         tick;
  logic         ready_seen_n;
  logic         hit;
  logic         claim_go;
  logic         foreign_end;
  logic         armed_r;
  logic [31:0]  rdata_r;

  assign dbl_mode  = (bus_mode != lbhp_pkg::LBHP_WIDE_SGL);
  assign wide_mode = (bus_mode != lbhp_pkg::LBHP_NARROW_DBL);

  assign clk_src  = dbl_mode ? bus.ready_return_n : bus.single_rate_clock;
  assign src_rise = clk_src && !src_prev_r;
  // In double modes only every second rise is a bus state edge.
  assign tick     = dbl_mode ? (src_rise && !phase_r && !bus.cpu_reset) : src_rise;

  // the ready wire is seen on whichever pin carries it.
  assign ready_seen_n = dbl_mode ? bus.ready_line_n : bus.ready_return_n;
  assign foreign_end  = dbl_mode && !ready_seen_n && bus.rdy_oe_n;

  assign hit = bus.mem_io_sel ? (bus.bus_addr[23:17] == lbhp_pkg::MEM_WIN) :
                                (bus.bus_addr[15:4] == lbhp_pkg::IO_WIN);
  // low strobe seen at a bus edge.
  assign claim_go = (state_r == D_IDLE) && tick && !bus.cycle_start_strobe_n && hit;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= clk_src;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'b0;
    end else if (bus.cpu_reset && dbl_mode) begin
      phase_r <= 1'b0;
    end else if (src_rise && dbl_mode) begin
      phase_r <= !phase_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      D_IDLE: begin
        if (claim_go) begin
          state_nxt = D_CLAIM;
        end
      end
      D_CLAIM: begin
        if (foreign_end) begin
          state_nxt = D_IDLE;
        end else if (tick) begin
          state_nxt = D_ACCESS;
        end
      end
      D_ACCESS: begin
        if (foreign_end) begin
          state_nxt = D_IDLE;
        end else if (dev_ack) begin
          state_nxt = D_READY;
        end
      end
      D_READY: begin
        if (tick && armed_r) begin
          state_nxt = D_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= D_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The ready low must have stood through one host edge before release.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= (state_r == D_READY) && (state_nxt == D_READY);
    end
  end

  // Cycle attributes are latched when the strobe is seen on an address that hits.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dev_addr  <= 22'h0;
      dev_mem   <= 1'b0;
      dev_write <= 1'b0;
      dev_be    <= 4'h0;
    end else if (claim_go) begin
      dev_addr  <= bus.bus_addr;
      dev_mem   <= bus.mem_io_sel;
      dev_write <= bus.write_read_sel;
      if (wide_mode) begin
        dev_be <= {!bus.byte_lane3_enable_n, !bus.byte_lane2_enable_n,
                   !bus.byte_lane1_enable_n, !bus.byte_lane0_enable_n};
      end else begin
        // lane2 is low byte, lane0 is ignored.
        dev_be <= {2'b00, !bus.byte_lane1_enable_n, !bus.byte_lane2_enable_n};
      end
    end
  end

  // Write data is valid from T2, so the request waits for that edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dev_req   <= 1'b0;
      dev_wdata <= 32'h0;
    end else begin
      dev_req <= (state_r == D_CLAIM) && (state_nxt == D_ACCESS);
      if ((state_r == D_CLAIM) && (state_nxt == D_ACCESS)) begin
        // upper lanes ignored in narrow mode.
        dev_wdata <= wide_mode ? {bus.upper_data_lanes, bus.lower_data_lanes} :
                                 {16'h0, bus.lower_data_lanes};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
    end else if ((state_r == D_ACCESS) && dev_ack) begin
      rdata_r <= dev_rdata;
    end
  end

  // claim goes low one clock after the strobe edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.claim_o    <= 1'b0;
      bus.claim_oe_n <= 1'b1;
    end else begin
      bus.claim_o    <= 1'b0;
      bus.claim_oe_n <= (state_nxt == D_IDLE);
    end
  end

  // size16 only in wide modes, for I/O targets.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.narrow_o    <= 1'b0;
      bus.narrow_oe_n <= 1'b1;
    end else if (claim_go) begin
      bus.narrow_o    <= 1'b0;
      bus.narrow_oe_n <= !(wide_mode && !bus.mem_io_sel);
    end else if (state_nxt == D_IDLE) begin
      bus.narrow_o    <= 1'b0;
      bus.narrow_oe_n <= 1'b1;
    end
  end

  // ready driven only to end our own cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.rdy_o    <= 1'b0;
      bus.rdy_oe_n <= 1'b1;
    end else begin
      bus.rdy_o    <= 1'b0;
      bus.rdy_oe_n <= (state_nxt != D_READY);
    end
  end

  // data lanes driven only on our reads.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.dev_lower_o    <= 16'h0;
      bus.dev_lower_oe_n <= 1'b1;
      bus.dev_upper_o    <= 16'h0;
      bus.dev_upper_oe_n <= 1'b1;
    end else begin
      bus.dev_lower_o    <= (state_r == D_ACCESS) ? dev_rdata[15:0] : rdata_r[15:0];
      bus.dev_upper_o    <= (state_r == D_ACCESS) ? dev_rdata[31:16] : rdata_r[31:16];
      bus.dev_lower_oe_n <= !((state_nxt == D_READY) && !dev_write);
      bus.dev_upper_oe_n <= !((state_nxt == D_READY) && !dev_write && wide_mode);
    end
  end

  // sticky request; a new event beats a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_pending <= 1'b0;
    end else if (irq_event) begin
      irq_pending <= 1'b1;
    end else if (interrupt_control_reg[1]) begin
      irq_pending <= 1'b0;
    end
  end

  // the pin floats unless the enable bit is set.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.irq_o    <= 1'b0;
      bus.irq_oe_n <= 1'b1;
    end else begin
      bus.irq_o    <= irq_event || (irq_pending && !interrupt_control_reg[1]);
      bus.irq_oe_n <= !interrupt_control_reg[0];
    end
  end
endmodule : lbhp_device
`default_nettype wire

// ---- lbhp_pkg.sv ----
package lbhp_pkg;
  // Bus flavour, chosen by strap at board level.
  typedef enum logic [1:0] {
    LBHP_NARROW_DBL = 2'h0,
    LBHP_WIDE_DBL   = 2'h1,
    LBHP_WIDE_SGL   = 2'h3
  } lbhp_mode_e;

  // Ref clock cycles per half period of the double-rate clock.
  localparam logic [3:0] DBL_HALF_CYC    = 4'h2;
  // Double-rate falls held under processor reset after our own reset.
  localparam logic [2:0] CPU_RESET_FALLS = 3'h4;
  // Memory window: address bits 23:17 must match.
  localparam logic [6:0] MEM_WIN         = 7'h05;
  // I/O window: address bits 15:4 must match; I/O registers are 16 bits wide.
  localparam logic [11:0] IO_WIN         = 12'h03c;
  localparam logic [15:0] LANE_IDLE      = 16'hffff;
endpackage : lbhp_pkg

// ---- lbhp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lbhp_if;
  logic        byte_lane0_enable_n;
  logic        byte_lane1_enable_n;
  logic        byte_lane2_enable_n;
  logic        byte_lane3_enable_n;
  logic [23:2] bus_addr;
  logic        mem_io_sel;
  logic        write_read_sel;
  logic        cycle_start_strobe_n;
  logic [31:0] host_data_o;
  logic        host_data_oe_n;
  logic [15:0] dev_upper_o;
  logic        dev_upper_oe_n;
  logic [15:0] dev_lower_o;
  logic        dev_lower_oe_n;
  logic [15:0] upper_data_lanes;
  logic [15:0] lower_data_lanes;
  logic        narrow_o;
  logic        narrow_oe_n;
  logic        narrow_resource_n;
  logic        claim_o;
  logic        claim_oe_n;
  logic        device_claim_n;
  logic        rdy_o;
  logic        rdy_oe_n;
  logic        ready_line_n;
  logic        ready_return_n;
  logic        single_rate_clock;
  logic        cpu_reset;
  logic        irq_o;
  logic        irq_oe_n;

  // Wire levels: pulled up where nobody drives.
  assign upper_data_lanes  = !dev_upper_oe_n ? dev_upper_o :
                             !host_data_oe_n ? host_data_o[31:16] : lbhp_pkg::LANE_IDLE;
  assign lower_data_lanes  = !dev_lower_oe_n ? dev_lower_o :
                             !host_data_oe_n ? host_data_o[15:0] : lbhp_pkg::LANE_IDLE;
  assign narrow_resource_n = narrow_oe_n ? 1'b1 : narrow_o;
  assign device_claim_n    = claim_oe_n ? 1'b1 : claim_o;
  assign ready_line_n      = rdy_oe_n ? 1'b1 : rdy_o;

  modport dev (
    input  byte_lane0_enable_n, byte_lane1_enable_n, byte_lane2_enable_n,
    input  byte_lane3_enable_n, bus_addr, mem_io_sel, write_read_sel,
    input  cycle_start_strobe_n, upper_data_lanes, lower_data_lanes, ready_line_n,
    input  ready_return_n, single_rate_clock, cpu_reset,
    output dev_upper_o, dev_upper_oe_n, dev_lower_o, dev_lower_oe_n,
    output narrow_o, narrow_oe_n, claim_o, claim_oe_n, rdy_o, rdy_oe_n, irq_o, irq_oe_n
  );
  modport host (
    output byte_lane0_enable_n, byte_lane1_enable_n, byte_lane2_enable_n,
    output byte_lane3_enable_n, bus_addr, mem_io_sel, write_read_sel,
    output cycle_start_strobe_n, host_data_o, host_data_oe_n,
    output ready_return_n, single_rate_clock, cpu_reset,
    input  upper_data_lanes, lower_data_lanes, narrow_resource_n, device_claim_n,
    input  ready_line_n, irq_o, irq_oe_n
  );
endinterface : lbhp_if
`default_nettype wire

// ---- lbhp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbhp_host (
  lbhp_if.host                   bus,
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire lbhp_pkg::lbhp_mode_e bus_mode,
  input  wire logic              req,
  input  wire logic [23:2]       req_addr,
  input  wire logic              req_mem,
  input  wire logic              req_write,
  input  wire logic [3:0]        req_be,
  input  wire logic [31:0]       req_wdata,
  output logic                   busy,
  output logic                   done,
  output logic                   no_claim,
  output logic [31:0]            rdata
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_T1 = 2'b01, H_T2 = 2'b11} lbhp_hstate_e;

  lbhp_hstate_e state_r;
  logic [3:0]   div_r;
  logic         dbl_r;
  logic         sgl_r;
  logic [2:0]   rst_cnt_r;
  logic         tick;
  logic         dbl_rise;
  logic         narrow_mode;
  logic [3:0]   be_r;
  logic         split_r;
  logic         split_go;

  assign narrow_mode = (bus_mode == lbhp_pkg::LBHP_NARROW_DBL);
  assign dbl_rise    = (div_r == lbhp_pkg::DBL_HALF_CYC - 4'h1) && !dbl_r;
  assign tick        = dbl_rise && !sgl_r && !bus.cpu_reset;
  assign split_go    = !narrow_mode && !bus.narrow_resource_n && !split_r &&
                       (|be_r[1:0]) && (|be_r[3:2]);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 4'h0;
      dbl_r <= 1'b0;
      sgl_r <= 1'b0;
    end else begin
      div_r <= (div_r == lbhp_pkg::DBL_HALF_CYC - 4'h1) ? 4'h0 : div_r + 4'h1;
      if (div_r == lbhp_pkg::DBL_HALF_CYC - 4'h1) begin
        dbl_r <= !dbl_r;
      end
      if (dbl_rise) begin
        sgl_r <= bus.cpu_reset ? 1'b0 : !sgl_r;
      end
    end
  end

  // Processor reset spans a few double-rate periods and drops on a fall.
  // processor reset drive.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_r     <= lbhp_pkg::CPU_RESET_FALLS;
      bus.cpu_reset <= 1'b1;
    end else if ((div_r == lbhp_pkg::DBL_HALF_CYC - 4'h1) && dbl_r && bus.cpu_reset) begin
      rst_cnt_r     <= rst_cnt_r - 3'h1;
      bus.cpu_reset <= (rst_cnt_r != 3'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus.ready_return_n    <= 1'b1;
      bus.single_rate_clock <= 1'b0;
    end else if (bus_mode == lbhp_pkg::LBHP_WIDE_SGL) begin
      bus.ready_return_n    <= bus.ready_line_n;
      bus.single_rate_clock <= dbl_rise ? !sgl_r && !bus.cpu_reset : sgl_r;
    end else begin
      bus.ready_return_n    <= div_r == lbhp_pkg::DBL_HALF_CYC - 4'h1 ? !dbl_r : dbl_r;
      bus.single_rate_clock <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r                  <= H_IDLE;
      busy                     <= 1'b0;
      done                     <= 1'b0;
      no_claim                 <= 1'b0;
      rdata                    <= 32'h0;
      be_r                     <= 4'h0;
      split_r                  <= 1'b0;
      bus.cycle_start_strobe_n <= 1'b1;
      bus.bus_addr             <= 22'h0;
      bus.mem_io_sel           <= 1'b0;
      bus.write_read_sel       <= 1'b0;
      bus.host_data_o          <= 32'h0;
      bus.host_data_oe_n       <= 1'b1;
      bus.byte_lane0_enable_n  <= 1'b1;
      bus.byte_lane1_enable_n  <= 1'b1;
      bus.byte_lane2_enable_n  <= 1'b1;
      bus.byte_lane3_enable_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      if (req && !busy) begin
        busy               <= 1'b1;
        no_claim           <= 1'b0;
        split_r            <= 1'b0;
        be_r               <= narrow_mode ? {2'b00, req_be[1:0]} : req_be;
        bus.bus_addr       <= req_addr;
        bus.mem_io_sel     <= req_mem;
        bus.write_read_sel <= req_write;
        bus.host_data_o    <= narrow_mode ? {16'h0, req_wdata[15:0]} : req_wdata;
      end
      unique case (state_r)
        H_IDLE: begin
          if (tick && busy) begin
            state_r                  <= H_T1;
            bus.cycle_start_strobe_n <= 1'b0;
            if (narrow_mode) begin
              bus.byte_lane2_enable_n <= !be_r[0];
              bus.byte_lane1_enable_n <= !be_r[1];
              bus.byte_lane0_enable_n <= 1'b0;
              bus.byte_lane3_enable_n <= 1'b1;
            end else begin
              bus.byte_lane0_enable_n <= !be_r[0];
              bus.byte_lane1_enable_n <= !be_r[1];
              bus.byte_lane2_enable_n <= !be_r[2];
              bus.byte_lane3_enable_n <= !be_r[3];
            end
          end
        end
        H_T1: begin
          if (tick) begin
            state_r                  <= H_T2;
            bus.cycle_start_strobe_n <= 1'b1;
            bus.host_data_oe_n       <= !bus.write_read_sel;
          end
        end
        H_T2: begin
          if (tick && (!bus.ready_line_n || bus.device_claim_n)) begin
            if (!bus.write_read_sel) begin
              rdata <= narrow_mode ? {16'h0, bus.lower_data_lanes} :
                       {bus.upper_data_lanes, bus.lower_data_lanes};
            end
            bus.host_data_oe_n <= 1'b1;
            if (!bus.ready_line_n && split_go) begin
              // narrow resource splits access.
              // The second half opens at the next tick, once the device is idle again.
              split_r                  <= 1'b1;
              be_r                     <= {be_r[3:2], 2'b00};
              state_r                  <= H_IDLE;
            end else begin
              state_r  <= H_IDLE;
              busy     <= 1'b0;
              done     <= 1'b1;
              no_claim <= bus.device_claim_n;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule : lbhp_host
`default_nettype wire

// ---- lbhp_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbhp_monitor (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire lbhp_pkg::lbhp_mode_e bus_mode,
  input wire logic                 byte_lane0_enable_n,
  input wire logic                 byte_lane3_enable_n,
  input wire logic [23:2]          bus_addr,
  input wire logic                 mem_io_sel,
  input wire logic                 write_read_sel,
  input wire logic                 cycle_start_strobe_n,
  input wire logic                 dev_upper_oe_n,
  input wire logic                 dev_lower_oe_n,
  input wire logic                 narrow_resource_n,
  input wire logic                 narrow_oe_n,
  input wire logic                 device_claim_n,
  input wire logic                 rdy_oe_n,
  input wire logic                 ready_line_n,
  input wire logic                 single_rate_clock,
  input wire logic                 cpu_reset
);
  logic hit;
  logic narrow;

  assign hit = mem_io_sel ? (bus_addr[23:17] == lbhp_pkg::MEM_WIN)
                          : (bus_addr[15:4] == lbhp_pkg::IO_WIN);
  assign narrow = (bus_mode == lbhp_pkg::LBHP_NARROW_DBL);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  strobe_width_a: assert property ($fell(cycle_start_strobe_n) |->
    !cycle_start_strobe_n [*8] ##1 cycle_start_strobe_n) else $error("strobe width wrong");
  claim_hit_a: assert property ($fell(cycle_start_strobe_n) && hit |->
    ##[1:11] !device_claim_n) else $error("claim late or missing");
  claim_miss_a: assert property ($fell(cycle_start_strobe_n) && !hit |->
    device_claim_n [*8]) else $error("claim on a miss");
  size_reply_a: assert property ($fell(device_claim_n) && !narrow |->
    narrow_resource_n == mem_io_sel) else $error("bus size reply wrong");
  size_idle_a: assert property (narrow |-> narrow_oe_n)
    else $error("bus size driven in narrow mode");
  upper_quiet_a: assert property (narrow |-> dev_upper_oe_n)
    else $error("upper lanes driven in narrow mode");
  lanes_read_a: assert property ($fell(dev_lower_oe_n) |->
    !write_read_sel && !device_claim_n) else $error("lanes driven off a claimed read");
  ready_own_a: assert property (!rdy_oe_n |-> !device_claim_n)
    else $error("ready driven outside own cycle");
  ready_release_a: assert property ($fell(ready_line_n) |->
    ##[1:20] ready_line_n) else $error("ready held too long");
  lane_enable_a: assert property (narrow && !cycle_start_strobe_n |->
    !byte_lane0_enable_n && byte_lane3_enable_n) else $error("narrow byte enables wrong");
  slow_ground_a: assert property (bus_mode != lbhp_pkg::LBHP_WIDE_SGL |->
    !single_rate_clock) else $error("single clock not grounded");
  phase_hold_a: assert property (cpu_reset |-> cycle_start_strobe_n)
    else $error("cycle under processor reset");

  cover property ($fell(device_claim_n) && !narrow_resource_n);
  cover property ($fell(dev_lower_oe_n));
  cover property ($fell(cycle_start_strobe_n) && !hit);
endmodule : lbhp_monitor
`default_nettype wire

// ---- tb_local_bus_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_local_bus_host_port;
  localparam logic [23:2] MEM_A = 22'h028010;
  localparam logic [23:2] IO_A  = 22'h0000f0;
  localparam logic [31:0] WD    = 32'ha5c3_5a3c;
  localparam logic [31:0] RD    = 32'h1e2d_3c4b;

  logic                 ref_clk, resetn, req, req_mem, req_write, done, no_claim;
  logic                 dev_ack, irq_event, dev_req, dev_mem, dev_write, irq_pending;
  logic                 cap_wr, cap_mem, busy;
  lbhp_pkg::lbhp_mode_e bus_mode;
  logic [23:2]          req_addr, dev_addr;
  logic [3:0]           req_be, dev_be, cap_be;
  logic [31:0]          req_wdata, dev_rdata, rdata, dev_wdata, cap_wd;
  logic [1:0]           interrupt_control_reg;
  int                   n_mismatch, comparisons, n_req, ack_wait;

  lbhp_if bus ();
  lbhp_host u_lbhp_host (.bus(bus.host), .ref_clk, .resetn, .bus_mode, .req, .req_addr,
    .req_mem, .req_write, .req_be, .req_wdata, .busy, .done, .no_claim, .rdata);
  lbhp_device u_lbhp_device (.bus(bus.dev), .ref_clk, .resetn, .bus_mode, .dev_ack,
    .dev_rdata, .irq_event, .interrupt_control_reg, .dev_req, .dev_addr, .dev_mem,
    .dev_write, .dev_be, .dev_wdata, .irq_pending);
  lbhp_monitor u_lbhp_monitor (.ref_clk, .resetn, .bus_mode,
    .byte_lane0_enable_n(bus.byte_lane0_enable_n), .byte_lane3_enable_n(bus.byte_lane3_enable_n),
    .bus_addr(bus.bus_addr), .mem_io_sel(bus.mem_io_sel), .write_read_sel(bus.write_read_sel),
    .cycle_start_strobe_n(bus.cycle_start_strobe_n), .dev_upper_oe_n(bus.dev_upper_oe_n),
    .dev_lower_oe_n(bus.dev_lower_oe_n), .narrow_resource_n(bus.narrow_resource_n),
    .narrow_oe_n(bus.narrow_oe_n), .device_claim_n(bus.device_claim_n),
    .rdy_oe_n(bus.rdy_oe_n), .ready_line_n(bus.ready_line_n),
    .single_rate_clock(bus.single_rate_clock), .cpu_reset(bus.cpu_reset));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : step

  task automatic reset_to(input lbhp_pkg::lbhp_mode_e m);
    resetn = 1'b0;
    bus_mode = m;
    step(6);
    resetn = 1'b1;
  endtask : reset_to

  // One host transfer; the first call after reset also waits out processor reset.
  task automatic xfer(input logic [23:2] a, input logic m, input logic w,
                      input logic [3:0] be, input logic [31:0] wd);
    int i;
    n_req = 0;
    step(2);
    req = 1'b1;
    req_addr = a;
    req_mem = m;
    req_write = w;
    req_be = be;
    req_wdata = wd;
    step(1);
    req = 1'b0;
    chk(busy, 1);
    for (i = 0; i < 400 && done !== 1'b1; i++) step(1);
    if (i == 400) begin
      chk(done, 1);
      stop_test();
    end
  endtask : xfer

  // Back end: answers at once or after a stall, as ack_wait says.
  initial begin
    dev_ack = 1'b0;
    dev_rdata = 32'h0;
    forever begin
      step(1);
      if (dev_req === 1'b1) begin
        n_req++;
        cap_be = dev_be;
        cap_wd = dev_wdata;
        cap_wr = dev_write;
        cap_mem = dev_mem;
        step(ack_wait);
        dev_ack = 1'b1;
        dev_rdata = RD;
        step(1);
        dev_ack = 1'b0;
        dev_rdata = ~RD;
      end
    end
  end

  task automatic t_wide_mem(input lbhp_pkg::lbhp_mode_e m);
    reset_to(m);
    ack_wait = 0;
    xfer(MEM_A, 1'b1, 1'b1, 4'hf, WD);
    chk(no_claim, 0);
    chk(cap_wr, 1);
    chk(cap_mem, 1);
    chk(cap_be, 4'hf);
    chk(cap_wd, WD);
    chk(dev_addr, MEM_A);
    ack_wait = 5;
    xfer(MEM_A, 1'b1, 1'b0, 4'hf, 32'h0);
    chk(cap_wr, 0);
    chk(rdata, RD);
  endtask : t_wide_mem

  task automatic t_decode;
    ack_wait = 0;
    xfer(IO_A, 1'b1, 1'b0, 4'h3, 32'h0);
    chk(no_claim, 1);
    chk(n_req, 0);
    xfer(MEM_A, 1'b0, 1'b0, 4'h3, 32'h0);
    chk(no_claim, 1);
    xfer(IO_A, 1'b0, 1'b1, 4'hf, WD);
    chk(no_claim, 0);
    chk(cap_mem, 0);
    chk(n_req, 2);
    chk(cap_be, 4'hc);
    chk(cap_wd[31:16], WD[31:16]);
    chk(dev_addr, IO_A);
  endtask : t_decode

  task automatic t_narrow;
    reset_to(lbhp_pkg::LBHP_NARROW_DBL);
    ack_wait = 3;
    xfer(MEM_A, 1'b1, 1'b1, 4'h2, WD);
    chk(cap_be, 4'h2);
    chk(cap_wd[15:8], WD[15:8]);
    xfer(MEM_A, 1'b1, 1'b0, 4'h3, 32'h0);
    chk(cap_be, 4'h3);
    chk(rdata[15:0], RD[15:0]);
  endtask : t_narrow

  task automatic t_irq;
    interrupt_control_reg = 2'h1;
    irq_event = 1'b1;
    step(1);
    irq_event = 1'b0;
    step(1);
    chk(irq_pending, 1);
    chk(bus.irq_oe_n, 0);
    chk(bus.irq_o, 1);
    interrupt_control_reg = 2'h0;
    step(2);
    chk(bus.irq_oe_n, 1);
    chk(irq_pending, 1);
    interrupt_control_reg = 2'h2;
    step(2);
    chk(irq_pending, 0);
    irq_event = 1'b1;
    step(1);
    irq_event = 1'b0;
    chk(irq_pending, 1);
    step(1);
    chk(irq_pending, 0);
  endtask : t_irq

  initial begin
    resetn = 1'b0;
    bus_mode = lbhp_pkg::LBHP_WIDE_DBL;
    {req, req_mem, req_write, irq_event} = 4'h0;
    req_addr = 22'h0;
    req_be = 4'h0;
    req_wdata = 32'h0;
    interrupt_control_reg = 2'h0;
    n_mismatch = 0;
    comparisons = 0;
    ack_wait = 0;
    t_wide_mem(lbhp_pkg::LBHP_WIDE_DBL);
    t_decode();
    t_wide_mem(lbhp_pkg::LBHP_WIDE_SGL);
    t_decode();
    t_narrow();
    t_irq();
    stop_test();
  end
endmodule : tb_local_bus_host_port
`default_nettype wire
